/* File: hdl/cfp_protect.sv */
`timescale 1ns/100ps
// Summary of operation
// - writing one to the calibration request bit asks for calibration mode
// - calibration entered only with all setpoints zero and enable bits one
// - request while any channel operates is discarded, bit reads zero
// - in calibration each transistor follows its own direct control bit
// - in calibration feedback carries 16-bit average current, 65535 is 1.5 A
// - feedback invalid while programmed PWM period is zero
// - no current limiting while calibration mode is active
// - overcurrent turns channel off, clears setpoint and enable, latches fault
// - latched overcurrent bit clears when diagnosis is read
// - current above high limit shuts down at once
// - between limits, shutdown only if overcurrent outlasts filter time
// - fault type follows configuration and failing transistor
// - overtemperature turns off and clears the overheated channel
// - after heat or voltage shutdown channel stays off until read and rewritten
// - overtemperature bit holds until read and condition gone
// - overvoltage bit sets, holds until read and condition gone
// - while overvoltage lasts all channels stay disabled and cleared
// - filter starts at low limit, lasts 20 to 40 cycles
module cfp_protect #(
    parameter int FILT_CYC = cfp_pkg::FILT_DEF_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire cfp_pkg::cfp_cmd_t i_cmd,
    input wire cfp_pkg::cfp_sense_t i_sense,
    input wire logic [cfp_pkg::NCH-1:0] i_high_side_config,
    input wire logic [cfp_pkg::NCH-1:0][1:0] i_reg_gate,
    input wire logic [cfp_pkg::NCH-1:0][cfp_pkg::FB_W-1:0] i_cal_avg,
    output logic [cfp_pkg::NCH-1:0][1:0] o_gate,
    output logic [cfp_pkg::NCH-1:0][cfp_pkg::SP_W-1:0] o_setpoint,
    output logic [cfp_pkg::NCH-1:0] o_enable,
    output logic o_cal_mode,
    output cfp_pkg::cfp_diag_t o_diag,
    output logic [cfp_pkg::NCH-1:0][cfp_pkg::FB_W-1:0] o_feedback,
    output logic o_feedback_valid
);
    import cfp_pkg::*;

    // refuse filter lengths outside the window
    if (FILT_CYC < FILT_MIN_CYC || FILT_CYC > FILT_MAX_CYC)
    begin : g_bad_filt
        $error("cfp_protect: FILT_CYC outside filter window");
    end

    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILT_CYC - 1);

    cfp_state_t state_ff;
    cfp_state_t nxt_state;
    cfp_sense_t sns;
    logic [NCH-1:0] active;
    logic [NCH-1:0] stage_chg;
    logic [NCH-1:0] trip_hs;
    logic [NCH-1:0] trip_ls;
    logic [NCH-1:0] kill;
    logic [NCH-1:0] lock;
    logic any_ot;
    logic sp_all_zero;

    // channel running: enabled with a nonzero setpoint
    function automatic logic ch_running(input logic en, input logic [SP_W-1:0] sp);
        ch_running = en && (sp != SP_ZERO);
    endfunction : ch_running

    // synchronised comparator view
    assign sns = state_ff.sync2;
    assign any_ot = |{state_ff.diag.over_temp_fault, sns.ch[0].over_temp, sns.ch[1].over_temp};

    // per-channel protection terms
    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
        assign active[c] = ch_running(state_ff.en[c], state_ff.sp[c]);
        assign stage_chg[c] = state_ff.gate[c] != state_ff.gate_prev[c];
        // quick trip above high limit, filtered trip above low limit
        assign trip_hs[c] = active[c] && !state_ff.cal && (sns.ch[c].oc_high_hs
            || (sns.ch[c].oc_low_hs && !stage_chg[c]
            && state_ff.cnt[c] == CNT_LAST));
        assign trip_ls[c] = active[c] && !state_ff.cal && (sns.ch[c].oc_high_ls
            || (sns.ch[c].oc_low_ls && !stage_chg[c]
            && state_ff.cnt[c] == CNT_LAST));
        assign kill[c] = trip_hs[c] || trip_ls[c] || sns.ch[c].over_temp
            || sns.over_volt;
        assign lock[c] = state_ff.diag.overcurrent_fault[c]
            || state_ff.diag.open_load_bypass_fault[c]
            || state_ff.diag.over_temp_fault[c]
            || state_ff.diag.over_volt_fault;
    end

    // all setpoints zero and all enables one
    always_comb
    begin
        sp_all_zero = 1'b1;
        for (int c = 0; c < NCH; c++)
        begin
            if (state_ff.sp[c] != SP_ZERO || !state_ff.en[c])
            begin
                sp_all_zero = 1'b0;
            end
        end
    end

    // next state
    always_comb
    begin
        logic rd_seen;
        rd_seen = 1'b0;
        nxt_state = state_ff;
        // two-stage synchroniser for the comparators
        nxt_state.sync1 = i_sense;
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.gate_prev = state_ff.gate;

        // calibration request write
        if (i_cmd.cal_wr)
        begin
            if (!i_cmd.calibration_mode_request)
            begin
                nxt_state.cal = 1'b0;
                nxt_state.direct = '0;
            end
            else if (sp_all_zero && !sns.over_volt && !any_ot)
            begin
                nxt_state.cal = 1'b1;
                nxt_state.direct = i_cmd.direct_transistor_control;
            end
            // otherwise the write is dropped
        end
        // heat or voltage fault ends calibration
        if (sns.over_volt || any_ot)
        begin
            nxt_state.cal = 1'b0;
            nxt_state.direct = '0;
        end

        for (int c = 0; c < NCH; c++)
        begin
            // filter counter
            if (!active[c] || state_ff.cal || stage_chg[c]
                || !(sns.ch[c].oc_low_hs || sns.ch[c].oc_low_ls))
            begin
                nxt_state.cnt[c] = CNT_ZERO;
            end
            else if (state_ff.cnt[c] != CNT_LAST)
            begin
                nxt_state.cnt[c] = state_ff.cnt[c] + 1'b1;
            end

            // setpoint write, refused while a fault is latched
            if (i_cmd.sp_wr[c] && !lock[c])
            begin
                nxt_state.sp[c] = i_cmd.sp_val[c];
                nxt_state.en[c] = i_cmd.en_val[c];
            end
            if (kill[c])
            begin
                nxt_state.sp[c] = SP_ZERO;
                nxt_state.en[c] = 1'b0;
            end

            // gate drive
            if (kill[c])
            begin
                nxt_state.gate[c] = GATE_OFF;
            end
            else if (state_ff.cal)
            begin
                nxt_state.gate[c] = state_ff.direct[c];
            end
            else if (active[c])
            begin
                nxt_state.gate[c] = i_reg_gate[c];
            end
            else
            begin
                nxt_state.gate[c] = GATE_OFF;
            end

            // fault matrix; a set in the read cycle wins
            nxt_state.diag.overcurrent_fault[c] = (i_high_side_config[c] ? trip_hs[c]
                : trip_ls[c]) || (state_ff.diag.overcurrent_fault[c] && !i_cmd.diag_rd);
            nxt_state.diag.open_load_bypass_fault[c] = (i_high_side_config[c] ? trip_ls[c]
                : trip_hs[c]) || (sns.ch[c].open_load_on && state_ff.gate[c] != GATE_OFF)
                || (state_ff.diag.open_load_bypass_fault[c] && !i_cmd.diag_rd);

            // overtemperature clears after a read and the condition gone
            rd_seen = state_ff.ot_rd[c] || i_cmd.diag_rd;
            nxt_state.diag.over_temp_fault[c] = sns.ch[c].over_temp
                || (state_ff.diag.over_temp_fault[c] && !rd_seen);
            nxt_state.ot_rd[c] = nxt_state.diag.over_temp_fault[c] && rd_seen;

            // calibration readback
            nxt_state.fb[c] = state_ff.cal ? i_cal_avg[c] : FB_ZERO;
        end

        // overvoltage latch, same clearing scheme
        rd_seen = state_ff.ov_rd || i_cmd.diag_rd;
        nxt_state.diag.over_volt_fault = sns.over_volt
            || (state_ff.diag.over_volt_fault && !rd_seen);
        nxt_state.ov_rd = nxt_state.diag.over_volt_fault && rd_seen;

        nxt_state.fb_valid = state_ff.cal && (i_cmd.pwm_period != PWM_ZERO);
    end

    // state register
    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // outputs straight from the state register
    assign o_gate = state_ff.gate;
    assign o_setpoint = state_ff.sp;
    assign o_enable = state_ff.en;
    assign o_cal_mode = state_ff.cal;
    assign o_diag = state_ff.diag;
    assign o_feedback = state_ff.fb;
    assign o_feedback_valid = state_ff.fb_valid;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    // calibration entry and refusal
    sequence s_cal_req;
        i_cmd.cal_wr && i_cmd.calibration_mode_request;
    endsequence

    cal_entry_a: assert property (s_cal_req and (sp_all_zero && !sns.over_volt && !any_ot)
        |=> o_cal_mode)
        else $error("calibration request not honoured");
    cal_reject_a: assert property (s_cal_req and (!state_ff.cal && !sp_all_zero)
        |=> !o_cal_mode)
        else $error("calibration entered while channel operating");

    // calibration behaviour
    direct_drive_a: assert property (state_ff.cal && !sns.over_volt && kill == '0
        |=> o_gate == $past(state_ff.direct))
        else $error("gates not following direct control");
    cal_feedback_a: assert property (state_ff.cal |=> o_feedback == $past(i_cal_avg))
        else $error("calibration feedback mismatch");
    fb_invalid_a: assert property (i_cmd.pwm_period == PWM_ZERO |=> !o_feedback_valid)
        else $error("feedback valid with zero period");
    cal_no_limit_a: assert property (state_ff.cal
        |=> (o_diag.overcurrent_fault & ~$past(o_diag.overcurrent_fault)) == '0)
        else $error("overcurrent raised in calibration");

    // per-channel overcurrent, overtemperature and fault lock sequences
    for (genvar c = 0; c < NCH; c++)
    begin : g_chk
        sequence s_quick;
            active[c] && !state_ff.cal && sns.ch[c].oc_high_hs;
        endsequence
        sequence s_shut;
            o_gate[c] == GATE_OFF && o_setpoint[c] == SP_ZERO && !o_enable[c];
        endsequence
        quick_trip_a: assert property (s_quick |=> s_shut
            ##0 (o_diag.overcurrent_fault[c] || o_diag.open_load_bypass_fault[c]))
            else $error("high limit did not shut channel down");
        matrix_a: assert property (s_quick and !i_high_side_config[c]
            |=> o_diag.open_load_bypass_fault[c])
            else $error("wrong fault type for high-side transistor");
        filter_hold_a: assert property (active[c] && !state_ff.cal && state_ff.cnt[c] < CNT_LAST
            && !sns.ch[c].oc_high_hs && !sns.ch[c].oc_high_ls && !sns.over_volt
            && !sns.ch[c].over_temp |=> o_enable[c])
            else $error("shutdown before filter time");
        filter_reset_a: assert property (stage_chg[c] |=> state_ff.cnt[c] == CNT_ZERO)
            else $error("filter counter not restarted");
        read_clear_a: assert property (i_cmd.diag_rd && !trip_hs[c] && !trip_ls[c]
            |=> !o_diag.overcurrent_fault[c])
            else $error("overcurrent bit not cleared by read");
        ot_hold_a: assert property (o_diag.over_temp_fault[c] && sns.ch[c].over_temp
            |=> o_diag.over_temp_fault[c] && !o_enable[c])
            else $error("overtemperature bit dropped early");
        relock_a: assert property (o_diag.over_temp_fault[c] || o_diag.over_volt_fault
            |-> !o_enable[c] && o_setpoint[c] == SP_ZERO)
            else $error("channel re-enabled while fault latched");
    end

    // overvoltage
    ov_off_a: assert property (sns.over_volt |=> o_enable == '0 && o_setpoint == '0
        && o_gate == '0 && o_diag.over_volt_fault)
        else $error("overvoltage did not disable channels");
endmodule : cfp_protect

/* File: hdl/cfp_pkg.sv */
package cfp_pkg;
    // channel count and field widths
    localparam int NCH = 2;
    localparam int SP_W = 11;
    localparam int FB_W = 16;
    localparam int PWM_W = 12;
    localparam int CNT_W = 6;
    // gate vector bit positions
    localparam int GATE_HS = 0;
    localparam int GATE_LS = 1;
    // overcurrent filter window in system clock cycles
    localparam int FILT_MIN_CYC = 20;
    localparam int FILT_MAX_CYC = 40;
    localparam int FILT_DEF_CYC = (FILT_MIN_CYC + FILT_MAX_CYC) / 2;
    // reset and idle values
    localparam logic [SP_W-1:0] SP_ZERO = 11'h000;
    localparam logic [FB_W-1:0] FB_ZERO = 16'h0000;
    localparam logic [PWM_W-1:0] PWM_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [1:0] GATE_OFF = 2'h0;

    // commands decoded from the serial register port, same clock
    typedef struct packed {
        logic [NCH-1:0] sp_wr;
        logic [NCH-1:0][SP_W-1:0] sp_val;
        logic [NCH-1:0] en_val;
        logic cal_wr;
        logic calibration_mode_request;
        logic [NCH-1:0][1:0] direct_transistor_control;
        logic diag_rd;
        logic [PWM_W-1:0] pwm_period;
    } cfp_cmd_t;

    // comparator flags of one channel, asynchronous
    typedef struct packed {
        logic oc_low_hs;
        logic oc_high_hs;
        logic oc_low_ls;
        logic oc_high_ls;
        logic open_load_on;
        logic over_temp;
    } cfp_sense_ch_t;

    typedef struct packed {
        cfp_sense_ch_t [NCH-1:0] ch;
        logic over_volt;
    } cfp_sense_t;

    // latched diagnosis bits
    typedef struct packed {
        logic [NCH-1:0] overcurrent_fault;
        logic [NCH-1:0] open_load_bypass_fault;
        logic [NCH-1:0] over_temp_fault;
        logic over_volt_fault;
    } cfp_diag_t;

    // whole state of the block
    typedef struct packed {
        cfp_sense_t sync1;
        cfp_sense_t sync2;
        logic [NCH-1:0][SP_W-1:0] sp;
        logic [NCH-1:0] en;
        logic cal;
        logic [NCH-1:0][1:0] direct;
        logic [NCH-1:0][1:0] gate;
        logic [NCH-1:0][1:0] gate_prev;
        logic [NCH-1:0][CNT_W-1:0] cnt;
        cfp_diag_t diag;
        logic [NCH-1:0] ot_rd;
        logic ov_rd;
        logic [NCH-1:0][FB_W-1:0] fb;
        logic fb_valid;
    } cfp_state_t;
endpackage : cfp_pkg

/* File: testbench/cfp_mcu_model.sv */
`timescale 1ns/100ps
// controller side: pulses register commands on the same clock as the block
module cfp_mcu_model (
    input wire logic i_ref_clk,
    output cfp_pkg::cfp_cmd_t o_cmd
);
    import cfp_pkg::*;

    initial o_cmd = '0;

    // idle command keeps only the level field
    function automatic cfp_cmd_t idle();
        idle = '0;
        idle.pwm_period = o_cmd.pwm_period;
    endfunction : idle

    // one-cycle strobe; released data is inverted so stale values never look valid
    task automatic pulse(input cfp_cmd_t c);
        cfp_cmd_t r;
        @(posedge i_ref_clk);
        o_cmd <= c;
        @(posedge i_ref_clk);
        r = ~c;
        r.sp_wr = '0;
        r.cal_wr = 1'b0;
        r.diag_rd = 1'b0;
        r.pwm_period = c.pwm_period;
        o_cmd <= r;
    endtask : pulse

    // restart writes enable and setpoint together, optionally after a pause
    task automatic write_sp(input int ch, input logic [SP_W-1:0] v, input logic en, input int gap);
        cfp_cmd_t c;
        c = idle();
        repeat (gap) @(posedge i_ref_clk);
        c.sp_wr[ch] = 1'b1;
        c.sp_val[ch] = v;
        c.en_val[ch] = en;
        pulse(c);
    endtask : write_sp

    // calibration request with per-transistor direct bits
    task automatic write_cal(input logic req, input logic [3:0] d);
        cfp_cmd_t c;
        c = idle();
        c.cal_wr = 1'b1;
        c.calibration_mode_request = req;
        c.direct_transistor_control = d;
        pulse(c);
    endtask : write_cal

    // diagnosis read, needed before any restart
    task automatic read_diag();
        cfp_cmd_t c;
        c = idle();
        c.diag_rd = 1'b1;
        pulse(c);
    endtask : read_diag

    task automatic set_pwm(input logic [PWM_W-1:0] p);
        @(posedge i_ref_clk);
        o_cmd.pwm_period <= p;
        // let the level settle so the next command keeps it
        @(posedge i_ref_clk);
    endtask : set_pwm
endmodule : cfp_mcu_model

/* File: testbench/calibration_and_fault_protection_bench.sv */
`timescale 1ns/100ps
module calibration_and_fault_protection_bench;
    import cfp_pkg::*;
    localparam int FILT = 20;
    typedef struct packed {
        logic [NCH-1:0][SP_W-1:0] sp;
        logic [NCH-1:0] en;
        logic cal;
        cfp_diag_t diag;
        logic [NCH-1:0][1:0] gate;
        logic [NCH-1:0][FB_W-1:0] fb;
        logic fbv;
    } cfp_exp_t;

    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    cfp_cmd_t cmd;
    cfp_sense_t sense = '0;
    logic [NCH-1:0] hs_cfg = '0;
    logic [NCH-1:0][1:0] reg_gate = '0;
    logic [NCH-1:0][FB_W-1:0] cal_avg = '0;
    logic [NCH-1:0][1:0] o_gate;
    logic [NCH-1:0][SP_W-1:0] o_setpoint;
    logic [NCH-1:0] o_enable;
    logic o_cal_mode;
    cfp_diag_t o_diag;
    logic [NCH-1:0][FB_W-1:0] o_feedback;
    logic o_feedback_valid;
    cfp_exp_t e = '0;
    cfp_exp_t got;
    cfp_exp_t q[$];
    logic sample_req = 1'b0;
    int num_errors = 0;
    int check_count = 0;
    int n;
    integer seed = 32'he196;
    logic [3:0] d;

    always #2.5 i_ref_clk = ~i_ref_clk;

    cfp_mcu_model mcu (.i_ref_clk(i_ref_clk), .o_cmd(cmd));

    cfp_protect #(.FILT_CYC(FILT)) dut (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_cmd(cmd), .i_sense(sense),
        .i_high_side_config(hs_cfg), .i_reg_gate(reg_gate), .i_cal_avg(cal_avg),
        .o_gate(o_gate), .o_setpoint(o_setpoint), .o_enable(o_enable),
        .o_cal_mode(o_cal_mode), .o_diag(o_diag), .o_feedback(o_feedback),
        .o_feedback_valid(o_feedback_valid)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // note the expected state one edge on, the monitor compares it
    task automatic snap();
        @(posedge i_ref_clk);
        q.push_back(e);
        sample_req <= 1'b1;
        @(posedge i_ref_clk);
        sample_req <= 1'b0;
    endtask : snap

    // start a channel with a random nonzero setpoint
    task automatic go(input int c);
        logic [SP_W-1:0] v;
        v = SP_W'($random(seed)) | 11'h001;
        mcu.write_sp(c, v, 1'b1, $unsigned($random(seed)) % 3);
        e.sp[c] = v;
        e.en[c] = 1'b1;
        e.gate[c] = reg_gate[c];
        snap();
    endtask : go

    // monitor: oldest note against settled outputs
    always @(negedge i_ref_clk)
    begin
        if (sample_req)
        begin
            got = q.pop_front();
            check(32'(o_setpoint), 32'(got.sp));
            check(32'(o_enable), 32'(got.en));
            check(32'(o_cal_mode), 32'(got.cal));
            check(32'(o_diag), 32'(got.diag));
            check(32'(o_gate), 32'(got.gate));
            check(32'(o_feedback), 32'(got.fb));
            if (got.cal)
                check(32'(o_feedback_valid), 32'(got.fbv));
        end
    end

    initial
    begin
        repeat (2) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        snap();
        mcu.set_pwm(12'h0A5);
        reg_gate <= 4'h5;
        hs_cfg <= 2'h3;
        go(0);
        go(1);
        // request refused while channels run
        mcu.write_cal(1'b1, 4'hF);
        snap();
        // fault assignment: k[0] config, k[1] failing transistor
        for (int k = 0; k < 4; k++)
        begin
            hs_cfg[0] <= k[0];
            reg_gate[0] <= k[1] ? 2'h2 : 2'h1;
            go(0);
            sense.ch[0].oc_high_hs <= !k[1];
            sense.ch[0].oc_high_ls <= k[1];
            repeat (2) @(posedge i_ref_clk);
            e.sp[0] = '0;
            e.en[0] = 1'b0;
            e.gate[0] = '0;
            e.diag.overcurrent_fault[0] = k[0] ^ k[1];
            e.diag.open_load_bypass_fault[0] = !(k[0] ^ k[1]);
            snap();
            sense.ch[0].oc_high_hs <= 1'b0;
            sense.ch[0].oc_high_ls <= 1'b0;
            repeat (3) @(posedge i_ref_clk);
            mcu.read_diag();
            e.diag = '0;
            snap();
        end
        hs_cfg <= 2'h3;
        reg_gate[0] <= 2'h1;
        go(0);
        // low threshold with a stage switch inside the filter window
        sense.ch[0].oc_low_hs <= 1'b1;
        repeat (12) @(posedge i_ref_clk);
        reg_gate[0] <= 2'h0;
        @(posedge i_ref_clk);
        reg_gate[0] <= 2'h1;
        repeat (12) @(posedge i_ref_clk);
        sense.ch[0].oc_low_hs <= 1'b0;
        snap();
        repeat (4) @(posedge i_ref_clk);
        sense.ch[0].oc_low_hs <= 1'b1;
        n = 0;
        do
        begin
            @(negedge i_ref_clk);
            n++;
        end
        while (o_enable[0] === 1'b1 && n < 60);
        if (n >= 60)
        begin
            num_errors++;
            conclude();
        end
        check(32'(n >= FILT && n <= FILT + 8), 32'h1);
        @(posedge i_ref_clk);
        sense.ch[0].oc_low_hs <= 1'b0;
        e.sp[0] = '0;
        e.en[0] = 1'b0;
        e.gate[0] = '0;
        e.diag.overcurrent_fault[0] = 1'b1;
        snap();
        repeat (3) @(posedge i_ref_clk);
        mcu.read_diag();
        e.diag = '0;
        go(0);
        // open load while on flags the bypass fault without shutdown
        sense.ch[0].open_load_on <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        e.diag.open_load_bypass_fault[0] = 1'b1;
        snap();
        sense.ch[0].open_load_on <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        mcu.read_diag();
        e.diag = '0;
        snap();
        // overtemperature on one channel, read while still hot
        sense.ch[1].over_temp <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        e.sp[1] = '0;
        e.en[1] = 1'b0;
        e.gate[1] = '0;
        e.diag.over_temp_fault[1] = 1'b1;
        snap();
        mcu.write_sp(1, 11'h055, 1'b1, 0);
        mcu.read_diag();
        snap();
        sense.ch[1].over_temp <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        e.diag.over_temp_fault[1] = 1'b0;
        go(1);
        // overvoltage clears every channel and blocks writes
        sense.over_volt <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        e.sp = '0;
        e.en = '0;
        e.gate = '0;
        e.diag.over_volt_fault = 1'b1;
        snap();
        mcu.read_diag();
        mcu.write_sp(0, 11'h0AA, 1'b1, 1);
        snap();
        sense.over_volt <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        e.diag.over_volt_fault = 1'b0;
        snap();
        // entry refused with one enable low
        mcu.write_sp(1, SP_ZERO, 1'b1, 0);
        mcu.write_cal(1'b1, 4'h5);
        e.en = 2'h2;
        snap();
        mcu.write_sp(0, SP_ZERO, 1'b1, 0);
        e.en = 2'h3;
        for (int p = 0; p < 2; p++)
        begin
            mcu.set_pwm(p ? PWM_ZERO : 12'h0A5);
            cal_avg <= {16'($random(seed)), 16'($random(seed))};
            d = 4'($random(seed));
            mcu.write_cal(1'b1, d);
            sense.ch[0].oc_high_hs <= 1'b1;
            repeat (3) @(posedge i_ref_clk);
            e.cal = 1'b1;
            e.gate = d;
            e.fb = cal_avg;
            e.fbv = (p == 0);
            snap();
            sense.ch[0].oc_high_hs <= 1'b0;
            repeat (3) @(posedge i_ref_clk);
            mcu.write_cal(1'b0, 4'h0);
            e.cal = 1'b0;
            e.gate = '0;
            e.fb = '0;
            snap();
        end
        conclude();
    end
endmodule : calibration_and_fault_protection_bench
